// >>> rtl/gdmc_consts.svh
// Constants of the gate driver operation-mode controller.
// Assumes a 100 MHz core clock; all times are converted here.
`ifndef GDMC_CONSTS_SVH
`define GDMC_CONSTS_SVH
`define GDMC_CLK_MHZ 100
`define GDMC_CFG_TO_MS 100
`define GDMC_CFG_TO_CYC (`GDMC_CFG_TO_MS * 1000 * `GDMC_CLK_MHZ)
`define GDMC_SIG_NS 1200
`define GDMC_SIG_CYC (`GDMC_SIG_NS * `GDMC_CLK_MHZ / 1000)
`define GDMC_ENA_CLR_NS 3000
`define GDMC_ENA_CLR_CYC ((`GDMC_ENA_CLR_NS * `GDMC_CLK_MHZ + 999) / 1000)
`define GDMC_EVT_ROP_BIT 0
`define GDMC_EVT_LIMP_BIT 1
`define GDMC_SUP_REG_ADDR 8'h43
`define GDMC_SUP_ROP_BIT 1
`define GDMC_SUP_VS_BIT 5
`define GDMC_SPI_SIG_BIT 3
`define GDMC_BEH_LATCH 2'h0
`define GDMC_BEH_AUTO 2'h1
`define GDMC_BEH_ERRPIN 2'h2
`define GDMC_BEH_WARN 2'h3
`endif

// >>> rtl/gdmc_pkg.sv
// Types of the gate driver operation-mode controller.
// Assumes nothing of its surroundings.
package gdmc_pkg;
  typedef enum logic [3:0] {
    ST_SLEEP, ST_IDLE, ST_CONFIG, ST_LOCK, ST_NORMAL, ST_LIMP, ST_REDUCED,
    ST_SAFEOFF, ST_ERROR, ST_SELFTEST, ST_PD_GATE, ST_PD_ANALOG, ST_PD_CB
  } gdmc_mode_type;
  typedef struct packed {
    logic [9:0] lowCnt;
    logic clear;
  } gdmc_filt_type;
endpackage : gdmc_pkg

// >>> rtl/gdmc_ena_if.sv
// Link between the mode core and the release-pin low-time filter.
// Both ends run on the same clock.
`timescale 1ns/1ps
interface gdmc_ena_if;
  logic enaLevel;
  logic clearPulse;
  modport filt (input enaLevel, output clearPulse);
  modport core (output enaLevel, input clearPulse);
endinterface : gdmc_ena_if

// >>> rtl/gdmc_ena_filter.sv
// Low-time filter of the driver release pin.
// Assumes the level it sees is already synchronised to clk.
`timescale 1ns/1ps
`include "gdmc_consts.svh"
module gdmc_ena_filter #(
  parameter int CLR_CYC = `GDMC_ENA_CLR_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Link to the mode core
  gdmc_ena_if.filt ena
);
  gdmc_pkg::gdmc_filt_type s_r;
  gdmc_pkg::gdmc_filt_type s_nxt;

  // Counting starts at the falling edge; the pulse fires once the low time is reached.
  always_comb begin
    s_nxt = s_r;
    s_nxt.clear = 1'b0;
    if (ena.enaLevel) begin
      s_nxt.lowCnt = '0;
    end else if (s_r.lowCnt != 10'(CLR_CYC)) begin
      s_nxt.lowCnt = s_r.lowCnt + 10'h001;
      s_nxt.clear = (s_r.lowCnt == 10'(CLR_CYC - 1)); // [R23]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ena.clearPulse = s_r.clear;

  property p_clear_long;
    @(posedge clk) disable iff (!reset_n)
    s_r.clear |-> s_r.lowCnt == 10'(CLR_CYC) && !$past(ena.enaLevel);
  endproperty
  a_clear_long: assert property (p_clear_long) else $error("clear without long low"); // [R23]

  property p_short_no_clear;
    @(posedge clk) disable iff (!reset_n)
    ena.enaLevel && s_r.lowCnt < 10'(CLR_CYC - 1) |=> !s_r.clear;
  endproperty
  a_short_no_clear: assert property (p_short_no_clear) else $error("short pulse cleared"); // [R23]
endmodule : gdmc_ena_filter

// >>> rtl/gdmc_mode_ctrl.sv
// Operation-mode controller of a three-phase gate driver.
// Assumes SPI decoding, supervision and error filters sit outside on clk;
// pins and analog monitors arrive asynchronously.
// Contract
// R1: Limp only when enabled during configuration.
// R2: Limp mode holds event bit 1.
// R3: Reduced mode keeps state, disables pins, amplifiers.
// R4: Reduced back to normal clears latched errors.
// R5: Host pulses release pin after logic-supply dip.
// R6: Passing reduced mode sets event bit 0.
// R7: Wake fall starts power-down, ignores wake after.
// R8: Power-down: gates off, analog off, then check.
// R9: Sleep after boost undervoltage; all off, core reset.
// R10: Sleep restores defaults; host reconfigures fully.
// R11: Idle from sleep on wake; fault high.
// R12: First valid configuration write enters configuration.
// R13: First command starts timer, fault pin low.
// R14: Matching signature enters normal, clears errors.
// R15: Signature result within 1.2 us, status bit 3.
// R16: Host sends default signature when nothing changes.
// R17: Reduced halts configuration; recovery restarts timer.
// R18: Timer expiry locks; wake cycle restarts.
// R19: Safe-off pin low forces transistors off.
// R20: Fault low means error; warnings excluded.
// R21: Latched errors need release reset; others recover.
// R22: Main supply sets bits 5,1; logic bit 1.
// R23: Release low 3.0 us clears latched errors.
// R24: Active mode visible as distinct status code.
// R25: Idle, configuration, lock hold gates off.
`timescale 1ns/1ps
`include "gdmc_consts.svh"
module gdmc_mode_ctrl #(
  parameter int NERR = 8,
  parameter logic [23:0] CFG_TO_CYC = 24'(`GDMC_CFG_TO_CYC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Host control pins
  input wire logic wakeInput,
  input wire logic driverReleasePin,
  input wire logic safeOffPin,
  // Analog monitors
  input wire logic vsLow,
  input wire logic vccLow,
  input wire logic boostCapUv,
  // SPI command decoder
  input wire logic spiWrValid,
  input wire logic spiWrCfg,
  input wire logic sigStrobe,
  input wire logic [7:0] sigByte,
  input wire logic [7:0] cfgCrc,
  input wire logic limpEnWr,
  input wire logic limpEnVal,
  input wire logic selfTestReq,
  input wire logic selfTestDone,
  // Supervision
  input wire logic limpReq,
  input wire logic [NERR-1:0] errCond,
  input wire logic [2*NERR-1:0] errBeh,
  // Status
  output gdmc_pkg::gdmc_mode_type opMode,
  output logic faultPin,
  output logic [7:0] eventReg,
  output logic [7:0] supplyReg,
  output logic [7:0] spiStatus,
  output logic [NERR-1:0] errLatched,
  output logic errClearPulse,
  output logic coreReset,
  output logic cfgTimerRun,
  // Power and output stage control
  output logic gateOff,
  output logic analogOn,
  output logic auxOn,
  output logic padsOn,
  output logic csaOn
);
  localparam int SY_WAKE = 0;
  localparam int SY_ENA = 1;
  localparam int SY_SAFE_OFF_PIN = 2;
  localparam int SY_VS = 3;
  localparam int SY_VCC = 4;
  localparam int SY_CB = 5;
  localparam logic [7:0] SIG_LAST = 8'(`GDMC_SIG_CYC - 1);
  localparam logic [23:0] CFG_LAST = CFG_TO_CYC - 24'h000001;

  typedef struct packed {
    logic [5:0] sy1;
    logic [5:0] sy2;
    logic wakePrev;
    gdmc_pkg::gdmc_mode_type mode;
    gdmc_pkg::gdmc_mode_type retMode;
    logic limpEn;
    logic [NERR-1:0] latch;
    logic [23:0] cfgCnt;
    logic [7:0] sigCnt;
    logic sigBusy;
    logic sigMatch;
    logic sigDone;
    logic [7:0] evt;
    logic [7:0] sup;
    logic fault;
    logic gateOn;
    logic analogOn;
    logic auxOn;
    logic padsOn;
    logic csaOn;
    logic clrErr;
    logic coreRst;
  } gdmc_core_type;

  gdmc_core_type s_r;
  gdmc_core_type s_nxt;
  gdmc_ena_if enaLink ();
  logic [NERR-1:0] latchSet;
  logic [NERR-1:0] liveErr;
  logic errActive;
  logic wake;
  logic soffHigh;
  logic vsL;
  logic ropCond;
  logic wakeFall;
  logic active;
  logic drive;

  gdmc_ena_filter u_filter (
    .clk(clk),
    .reset_n(reset_n),
    .ena(enaLink)
  );

  assign enaLink.enaLevel = s_r.sy2[SY_ENA];

  // Per-error behaviour: warnings never count, latched ones stick.
  for (genvar i = 0; i < NERR; i++) begin : g_err
    wire logic [1:0] beh = errBeh[2*i +: 2];
    assign latchSet[i] = errCond[i] && beh == `GDMC_BEH_LATCH; // [R21]
    assign liveErr[i] = errCond[i] &&
      (beh == `GDMC_BEH_AUTO || beh == `GDMC_BEH_ERRPIN); // [R20] [R21]
  end

  assign errActive = |(s_r.latch | liveErr);
  assign wake = s_r.sy2[SY_WAKE];
  assign soffHigh = s_r.sy2[SY_SAFE_OFF_PIN];
  assign vsL = s_r.sy2[SY_VS];
  assign ropCond = s_r.sy2[SY_VS] | s_r.sy2[SY_VCC];
  assign wakeFall = s_r.wakePrev & ~wake;
  assign active = !(s_r.mode inside {gdmc_pkg::ST_SLEEP, gdmc_pkg::ST_PD_GATE,
    gdmc_pkg::ST_PD_ANALOG, gdmc_pkg::ST_PD_CB});
  assign drive = s_r.mode inside {gdmc_pkg::ST_NORMAL, gdmc_pkg::ST_ERROR,
    gdmc_pkg::ST_LIMP, gdmc_pkg::ST_SELFTEST};

  always_comb begin
    s_nxt = s_r;
    s_nxt.sy1 = {boostCapUv, vccLow, vsLow, safeOffPin, driverReleasePin, wakeInput};
    s_nxt.sy2 = s_r.sy1;
    s_nxt.wakePrev = wake;
    s_nxt.clrErr = 1'b0;
    s_nxt.coreRst = 1'b0;
    unique case (s_r.mode)
      gdmc_pkg::ST_SLEEP: begin
        if (wake && !vsL) begin
          s_nxt.mode = gdmc_pkg::ST_IDLE; // [R11]
        end
      end
      gdmc_pkg::ST_IDLE: begin
        if (spiWrValid && spiWrCfg) begin
          s_nxt.mode = gdmc_pkg::ST_CONFIG; // [R12]
          s_nxt.cfgCnt = '0; // [R13]
        end
      end
      gdmc_pkg::ST_CONFIG: begin
        s_nxt.cfgCnt = s_r.cfgCnt + 24'h000001;
        if (limpEnWr) begin
          s_nxt.limpEn = limpEnVal; // [R1]
        end
        if (sigStrobe && !s_r.sigBusy) begin
          s_nxt.sigBusy = 1'b1;
          s_nxt.sigCnt = '0;
          s_nxt.sigDone = 1'b0;
          s_nxt.sigMatch = (sigByte == cfgCrc); // [R14]
        end else if (s_r.sigBusy) begin
          s_nxt.sigCnt = s_r.sigCnt + 8'h01;
          if (s_r.sigCnt == SIG_LAST) begin
            s_nxt.sigBusy = 1'b0;
            s_nxt.sigDone = 1'b1; // [R15]
            if (s_r.sigMatch) begin
              s_nxt.mode = gdmc_pkg::ST_NORMAL; // [R14]
              s_nxt.clrErr = 1'b1; // [R14]
            end
          end
        end
        if (s_r.cfgCnt == CFG_LAST && s_nxt.mode == gdmc_pkg::ST_CONFIG) begin
          s_nxt.mode = gdmc_pkg::ST_LOCK; // [R18]
          s_nxt.sigBusy = 1'b0;
        end
      end
      gdmc_pkg::ST_LOCK: begin
        s_nxt.mode = gdmc_pkg::ST_LOCK; // [R18]
      end
      gdmc_pkg::ST_NORMAL: begin
        if (selfTestReq) begin
          s_nxt.mode = gdmc_pkg::ST_SELFTEST;
        end else if (limpReq && s_r.limpEn) begin
          s_nxt.mode = gdmc_pkg::ST_LIMP; // [R1]
        end else if (errActive) begin
          s_nxt.mode = gdmc_pkg::ST_ERROR; // [R20]
        end
      end
      gdmc_pkg::ST_ERROR: begin
        if (!errActive) begin
          s_nxt.mode = gdmc_pkg::ST_NORMAL; // [R21]
        end
      end
      gdmc_pkg::ST_LIMP: begin
        if (!limpReq) begin
          s_nxt.mode = gdmc_pkg::ST_NORMAL;
        end
      end
      gdmc_pkg::ST_SELFTEST: begin
        if (selfTestDone) begin
          s_nxt.mode = gdmc_pkg::ST_NORMAL;
        end
      end
      gdmc_pkg::ST_SAFEOFF: begin
        if (soffHigh) begin
          s_nxt.mode = gdmc_pkg::ST_NORMAL; // [R19]
        end
      end
      gdmc_pkg::ST_REDUCED: begin
        if (!ropCond) begin
          s_nxt.mode = s_r.retMode;
          if (s_r.retMode == gdmc_pkg::ST_CONFIG) begin
            s_nxt.cfgCnt = '0; // [R17]
          end else if (s_r.retMode == gdmc_pkg::ST_NORMAL) begin
            s_nxt.clrErr = 1'b1; // [R4]
          end
        end
      end
      gdmc_pkg::ST_PD_GATE: begin
        s_nxt.mode = gdmc_pkg::ST_PD_ANALOG; // [R8]
      end
      gdmc_pkg::ST_PD_ANALOG: begin
        s_nxt.mode = gdmc_pkg::ST_PD_CB; // [R8]
      end
      gdmc_pkg::ST_PD_CB: begin
        if (s_r.sy2[SY_CB]) begin
          s_nxt.mode = gdmc_pkg::ST_SLEEP; // [R9]
          s_nxt.coreRst = 1'b1; // [R9]
        end
      end
      default: begin
        s_nxt.mode = gdmc_pkg::ST_SLEEP;
      end
    endcase
    // Overrides in priority order: wake fall, then supply dip, then safe-off.
    if (drive && !soffHigh) begin
      s_nxt.mode = gdmc_pkg::ST_SAFEOFF; // [R19]
    end
    if (active && s_r.mode != gdmc_pkg::ST_REDUCED && ropCond) begin
      s_nxt.mode = gdmc_pkg::ST_REDUCED; // [R3] [R17]
      s_nxt.clrErr = 1'b0;
      s_nxt.sigBusy = 1'b0;
      if (s_r.mode inside {gdmc_pkg::ST_IDLE, gdmc_pkg::ST_CONFIG, gdmc_pkg::ST_LOCK}) begin
        s_nxt.retMode = s_r.mode;
      end else begin
        s_nxt.retMode = gdmc_pkg::ST_NORMAL;
      end
      s_nxt.evt[`GDMC_EVT_ROP_BIT] = 1'b1; // [R6]
      s_nxt.sup[`GDMC_SUP_ROP_BIT] = 1'b1; // [R22]
      if (vsL) begin
        s_nxt.sup[`GDMC_SUP_VS_BIT] = 1'b1; // [R22]
      end
    end
    // Wake changes are only looked at in active modes, so power-down runs to sleep.
    if (active && wakeFall) begin
      s_nxt.mode = gdmc_pkg::ST_PD_GATE; // [R7]
      s_nxt.clrErr = 1'b0;
      s_nxt.sigBusy = 1'b0;
    end
    // The release-pin reset clears sticky status; a new latch set or a reduced-mode entry in the same cycle wins.
    if (enaLink.clearPulse || s_nxt.clrErr) begin
      s_nxt.latch = '0; // [R4] [R14] [R23]
    end
    if (enaLink.clearPulse) begin
      s_nxt.evt[`GDMC_EVT_ROP_BIT] = s_nxt.evt[`GDMC_EVT_ROP_BIT] & (s_nxt.mode == gdmc_pkg::ST_REDUCED && s_r.mode != gdmc_pkg::ST_REDUCED);
      s_nxt.sup = s_nxt.sup & s_nxt.sup & {8{s_nxt.mode == gdmc_pkg::ST_REDUCED && s_r.mode != gdmc_pkg::ST_REDUCED}};
    end
    s_nxt.latch = s_nxt.latch | latchSet; // [R21]
    s_nxt.evt[`GDMC_EVT_LIMP_BIT] = (s_nxt.mode == gdmc_pkg::ST_LIMP); // [R2]
    if (s_nxt.coreRst) begin
      s_nxt.limpEn = 1'b0; // [R10]
      s_nxt.latch = '0; // [R10]
      s_nxt.evt = '0; // [R10]
      s_nxt.sup = '0; // [R10]
      s_nxt.sigDone = 1'b0; // [R10]
      s_nxt.sigMatch = 1'b0;
      s_nxt.cfgCnt = '0;
    end
    s_nxt.gateOn = s_nxt.mode inside {gdmc_pkg::ST_NORMAL, gdmc_pkg::ST_ERROR,
      gdmc_pkg::ST_LIMP, gdmc_pkg::ST_SELFTEST}; // [R19] [R25] [R8]
    s_nxt.analogOn = !(s_nxt.mode inside {gdmc_pkg::ST_SLEEP,
      gdmc_pkg::ST_PD_ANALOG, gdmc_pkg::ST_PD_CB}); // [R8]
    s_nxt.auxOn = (s_nxt.mode != gdmc_pkg::ST_SLEEP); // [R9] [R3]
    s_nxt.padsOn = !(s_nxt.mode inside {gdmc_pkg::ST_SLEEP, gdmc_pkg::ST_REDUCED}); // [R3] [R9]
    s_nxt.csaOn = !(s_nxt.mode inside {gdmc_pkg::ST_SLEEP, gdmc_pkg::ST_REDUCED,
      gdmc_pkg::ST_PD_ANALOG, gdmc_pkg::ST_PD_CB}); // [R3] [R19]
    s_nxt.fault = (s_nxt.mode inside {gdmc_pkg::ST_IDLE, gdmc_pkg::ST_NORMAL,
      gdmc_pkg::ST_LIMP, gdmc_pkg::ST_SELFTEST}) ||
      (s_nxt.mode == gdmc_pkg::ST_SAFEOFF && !errActive); // [R11] [R13] [R20]
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign opMode = s_r.mode; // [R24]
  assign faultPin = s_r.fault;
  assign eventReg = s_r.evt;
  assign supplyReg = s_r.sup;
  assign spiStatus = {4'h0, s_r.sigDone, 3'h0};
  assign errLatched = s_r.latch;
  assign errClearPulse = s_r.clrErr;
  assign coreReset = s_r.coreRst;
  assign cfgTimerRun = (s_r.mode == gdmc_pkg::ST_CONFIG);
  assign gateOff = ~s_r.gateOn;
  assign analogOn = s_r.analogOn;
  assign auxOn = s_r.auxOn;
  assign padsOn = s_r.padsOn;
  assign csaOn = s_r.csaOn;

  property p_limp_enabled;
    @(posedge clk) disable iff (!reset_n)
    s_r.mode == gdmc_pkg::ST_LIMP |-> s_r.limpEn && eventReg[`GDMC_EVT_LIMP_BIT];
  endproperty
  a_limp_enabled: assert property (p_limp_enabled) else $error("limp not allowed"); // [R1] [R2]

  property p_reduced_quiet;
    @(posedge clk) disable iff (!reset_n)
    s_r.mode == gdmc_pkg::ST_REDUCED |-> !padsOn && !csaOn && auxOn && !faultPin;
  endproperty
  a_reduced_quiet: assert property (p_reduced_quiet) else $error("reduced pins active"); // [R3]

  property p_reduced_flag;
    @(posedge clk) disable iff (!reset_n)
    $rose(s_r.mode == gdmc_pkg::ST_REDUCED) |->
      eventReg[`GDMC_EVT_ROP_BIT] && supplyReg[`GDMC_SUP_ROP_BIT];
  endproperty
  a_reduced_flag: assert property (p_reduced_flag) else $error("reduced flag missing"); // [R6] [R22]

  property p_pd_order;
    @(posedge clk) disable iff (!reset_n)
    s_r.mode == gdmc_pkg::ST_PD_GATE |-> gateOff && analogOn ##1
      s_r.mode == gdmc_pkg::ST_PD_ANALOG && !analogOn ##1 s_r.mode == gdmc_pkg::ST_PD_CB;
  endproperty
  a_pd_order: assert property (p_pd_order) else $error("power-down order broken"); // [R7] [R8]

  property p_sleep_entry;
    @(posedge clk) disable iff (!reset_n)
    $past(s_r.mode) == gdmc_pkg::ST_PD_CB && s_r.mode == gdmc_pkg::ST_SLEEP |->
      $past(s_r.sy2[SY_CB]) && coreReset && !auxOn && !padsOn && !s_r.limpEn;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("bad sleep entry"); // [R9] [R10]

  property p_cfg_entry;
    @(posedge clk) disable iff (!reset_n)
    s_r.mode == gdmc_pkg::ST_IDLE && spiWrValid && spiWrCfg && !ropCond && !wakeFall |=>
      s_r.mode == gdmc_pkg::ST_CONFIG && !faultPin && s_r.cfgCnt == 24'h000000;
  endproperty
  a_cfg_entry: assert property (p_cfg_entry) else $error("config entry wrong"); // [R12] [R13]

  property p_sig_time;
    @(posedge clk) disable iff (!reset_n)
    $fell(s_r.sigBusy) && s_r.mode != gdmc_pkg::ST_REDUCED && s_r.mode != gdmc_pkg::ST_LOCK &&
      s_r.mode != gdmc_pkg::ST_PD_GATE |-> spiStatus[`GDMC_SPI_SIG_BIT] && $past(s_r.sigCnt) == SIG_LAST;
  endproperty
  a_sig_time: assert property (p_sig_time) else $error("signature timing wrong"); // [R15] [R14]

  property p_gates_off;
    @(posedge clk) disable iff (!reset_n)
    s_r.mode inside {gdmc_pkg::ST_IDLE, gdmc_pkg::ST_CONFIG, gdmc_pkg::ST_LOCK,
      gdmc_pkg::ST_SAFEOFF} |-> gateOff;
  endproperty
  a_gates_off: assert property (p_gates_off) else $error("gates not off"); // [R25] [R19]

  property p_error_fault;
    @(posedge clk) disable iff (!reset_n)
    s_r.mode == gdmc_pkg::ST_ERROR |-> !faultPin;
  endproperty
  a_error_fault: assert property (p_error_fault) else $error("fault high in error"); // [R20]
endmodule : gdmc_mode_ctrl

// >>> tb/gdmc_host_model.sv
// Host microcontroller model driving the control pins and the SPI decoder strobes.
// Assumes the core clock; every change lands just after a falling edge.
`timescale 1ns/1ps
module gdmc_host_model (
  // Clock
  input wire logic clk,
  // Control pins
  output logic wakeInput,
  output logic driverReleasePin,
  output logic safeOffPin,
  // SPI decoder side
  output logic spiWrValid,
  output logic spiWrCfg,
  output logic sigStrobe,
  output logic [7:0] sigByte,
  output logic limpEnWr,
  output logic limpEnVal
);
  initial begin
    {wakeInput, driverReleasePin, safeOffPin} = 3'h7;
    {spiWrValid, spiWrCfg, sigStrobe, limpEnWr, limpEnVal} = 5'h00;
    sigByte = 8'h5a;
  end

  task automatic set_pins(input logic w, input logic s);
    @(negedge clk);
    wakeInput = w;
    safeOffPin = s;
  endtask : set_pins

  // Opens configuration, then writes the limp enable; the whole set is rewritten after sleep.
  task automatic cfg_write(input logic lim);
    @(negedge clk);
    {spiWrValid, spiWrCfg} = 2'h3;
    @(negedge clk);
    {limpEnWr, limpEnVal} = {1'b1, lim};
    @(negedge clk);
    {spiWrValid, spiWrCfg, limpEnWr} = 3'h0;
    limpEnVal = ~lim;
  endtask : cfg_write

  // A released byte bus shows the inverse of the last value.
  task automatic send_sig(input logic [7:0] b);
    @(negedge clk);
    sigByte = b;
    sigStrobe = 1'b1;
    @(negedge clk);
    sigStrobe = 1'b0;
    sigByte = ~b;
  endtask : send_sig

  task automatic release_low(input int n);
    @(negedge clk);
    driverReleasePin = 1'b0;
    repeat (n) @(negedge clk);
    driverReleasePin = 1'b1;
  endtask : release_low
endmodule : gdmc_host_model

// >>> tb/gate_driver_mode_controller_tb.sv
// Self-checking bench of the gate driver operation-mode controller.
// Assumes the host model on the pin side; monitors are driven here.
`timescale 1ns/1ps
module gate_driver_mode_controller_tb;
  logic clk, reset_n, vsLow, vccLow, boostCapUv, selfTestReq, selfTestDone, limpReq;
  logic wakeInput, driverReleasePin, safeOffPin, spiWrValid, spiWrCfg, sigStrobe;
  logic limpEnWr, limpEnVal, faultPin, errClearPulse, coreReset, cfgTimerRun;
  logic gateOff, analogOn, auxOn, padsOn, csaOn, clrSeen, rstSeen, vsFirst;
  logic [7:0] sigByte, cfgCrc, errCond, eventReg, supplyReg, spiStatus, errLatched;
  logic [15:0] errBeh;
  logic [31:0] seed, rv;
  gdmc_pkg::gdmc_mode_type opMode;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;

  gdmc_host_model gdmc_host_model_inst (.clk, .wakeInput, .driverReleasePin, .safeOffPin,
    .spiWrValid, .spiWrCfg, .sigStrobe, .sigByte, .limpEnWr, .limpEnVal);

  gdmc_mode_ctrl #(.NERR(8), .CFG_TO_CYC(24'h000190)) gdmc_mode_ctrl_inst (.clk, .reset_n,
    .wakeInput, .driverReleasePin, .safeOffPin, .vsLow, .vccLow, .boostCapUv, .spiWrValid,
    .spiWrCfg, .sigStrobe, .sigByte, .cfgCrc, .limpEnWr, .limpEnVal, .selfTestReq,
    .selfTestDone, .limpReq, .errCond, .errBeh, .opMode, .faultPin, .eventReg, .supplyReg,
    .spiStatus, .errLatched, .errClearPulse, .coreReset, .cfgTimerRun, .gateOff, .analogOn,
    .auxOn, .padsOn, .csaOn);

  always #5 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Errors whose behaviour field says warning; they must never lead to error mode.
  function automatic logic [7:0] warn_mask(input logic [15:0] beh);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m[i] = (beh[2*i +: 2] == 2'h3);
    end
    return m;
  endfunction : warn_mask

  // Supply status after a dip: main supply sets bits 5 and 1, logic supply bit 1 only.
  function automatic logic [7:0] sup_exp(input logic vs);
    return vs ? 8'h22 : 8'h02;
  endfunction : sup_exp

  task automatic close_out();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cycles++;
    if (errClearPulse === 1'b1) clrSeen = 1'b1;
    if (coreReset === 1'b1) rstSeen = 1'b1;
    if (cycles == 20000) begin
      err_count++;
      close_out();
    end
  end

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_mode(input gdmc_pkg::gdmc_mode_type got, input gdmc_pkg::gdmc_mode_type exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_mode

  task automatic wait_mode(input gdmc_pkg::gdmc_mode_type m, input int n);
    int i;
    i = 0;
    while (opMode !== m && i < n) begin
      @(negedge clk);
      i++;
    end
    chk_mode(opMode, m);
  endtask : wait_mode

  task automatic note(input string s);
    $display("test %s done at %0t", s, $time);
  endtask : note

  task automatic pins(input logic w, input logic s);
    gdmc_host_model_inst.set_pins(w, s);
  endtask : pins

  initial begin
    {clk, reset_n, vsLow, vccLow, boostCapUv, selfTestReq, limpReq} = 7'h00;
    {errCond, seed} = {8'h00, 32'h2bd773d3};
    rv = rnd();
    cfgCrc = rv[7:0];
    selfTestDone = rv[8];
    vsFirst = rv[9];
    // Errors 0, 1 and 5 are latched, auto and warning; the others are drawn at random.
    errBeh = {rv[31:28], 2'h3, rv[27:22], 4'h4};
    repeat (2) @(negedge clk);
    chk_mode(opMode, gdmc_pkg::ST_SLEEP);
    reset_n = 1'b1;
    wait_mode(gdmc_pkg::ST_IDLE, 5);
    chk_val({6'h0, faultPin, gateOff}, 8'h03);
    note("reset");
    gdmc_host_model_inst.cfg_write(1'b1);
    chk_mode(opMode, gdmc_pkg::ST_CONFIG);
    chk_val({5'h0, faultPin, cfgTimerRun, gateOff}, 8'h03);
    rv = rnd();
    gdmc_host_model_inst.send_sig(cfgCrc ^ (rv[7:0] | 8'h01));
    repeat (119) @(negedge clk);
    chk_val(spiStatus & 8'h08, 8'h00);
    @(negedge clk);
    chk_val(spiStatus & 8'h08, 8'h08);
    chk_mode(opMode, gdmc_pkg::ST_CONFIG);
    clrSeen = 1'b0;
    gdmc_host_model_inst.send_sig(cfgCrc);
    wait_mode(gdmc_pkg::ST_NORMAL, 125);
    chk_val({6'h0, clrSeen | errClearPulse, faultPin}, 8'h03);
    note("config");
    limpReq = 1'b1;
    wait_mode(gdmc_pkg::ST_LIMP, 6);
    chk_val(eventReg & 8'h02, 8'h02);
    limpReq = 1'b0;
    wait_mode(gdmc_pkg::ST_NORMAL, 6);
    chk_val(eventReg & 8'h02, 8'h00);
    {selfTestReq, selfTestDone} = 2'h2;
    @(negedge clk);
    selfTestReq = 1'b0;
    wait_mode(gdmc_pkg::ST_SELFTEST, 5);
    selfTestDone = 1'b1;
    wait_mode(gdmc_pkg::ST_NORMAL, 6);
    selfTestDone = 1'b0;
    note("limp");
    clrSeen = 1'b0;
    {vsLow, vccLow} = vsFirst ? 2'h2 : 2'h1;
    wait_mode(gdmc_pkg::ST_REDUCED, 6);
    chk_val({6'h0, padsOn, csaOn}, 8'h00);
    chk_val(supplyReg, sup_exp(vsFirst));
    chk_val(eventReg & 8'h01, 8'h01);
    {vsLow, vccLow} = 2'h0;
    wait_mode(gdmc_pkg::ST_NORMAL, 6);
    chk_val({7'h0, clrSeen | errClearPulse}, 8'h01);
    gdmc_host_model_inst.release_low(100);
    repeat (4) @(negedge clk);
    chk_val(supplyReg, sup_exp(vsFirst));
    gdmc_host_model_inst.release_low(310);
    repeat (4) @(negedge clk);
    chk_val({eventReg[0], supplyReg[6:0]}, 8'h00);
    {vsLow, vccLow} = vsFirst ? 2'h1 : 2'h2;
    wait_mode(gdmc_pkg::ST_REDUCED, 6);
    chk_val(supplyReg, sup_exp(!vsFirst));
    {vsLow, vccLow} = 2'h0;
    wait_mode(gdmc_pkg::ST_NORMAL, 6);
    gdmc_host_model_inst.release_low(310);
    note("reduced");
    errCond = warn_mask(errBeh) & (rv[7:0] | 8'h20);
    repeat (8) @(negedge clk);
    chk_mode(opMode, gdmc_pkg::ST_NORMAL);
    errCond = 8'h01;
    wait_mode(gdmc_pkg::ST_ERROR, 8);
    chk_val({faultPin, errLatched[6:0]}, 8'h01);
    errCond = 8'h00;
    gdmc_host_model_inst.release_low(100);
    repeat (8) @(negedge clk);
    chk_mode(opMode, gdmc_pkg::ST_ERROR);
    gdmc_host_model_inst.release_low(310);
    wait_mode(gdmc_pkg::ST_NORMAL, 8);
    errCond = 8'h02;
    wait_mode(gdmc_pkg::ST_ERROR, 8);
    errCond = 8'h00;
    wait_mode(gdmc_pkg::ST_NORMAL, 8);
    note("error");
    pins(1'b1, 1'b0);
    wait_mode(gdmc_pkg::ST_SAFEOFF, 6);
    chk_val({5'h0, gateOff, csaOn, padsOn}, 8'h07);
    pins(1'b1, 1'b1);
    wait_mode(gdmc_pkg::ST_NORMAL, 6);
    pins(1'b0, 1'b1);
    wait_mode(gdmc_pkg::ST_PD_GATE, 5);
    chk_val({7'h0, gateOff}, 8'h01);
    pins(1'b1, 1'b1);
    wait_mode(gdmc_pkg::ST_PD_CB, 6);
    chk_val({7'h0, analogOn}, 8'h00);
    pins(1'b0, 1'b1);
    repeat (3) @(negedge clk);
    rstSeen = 1'b0;
    boostCapUv = 1'b1;
    wait_mode(gdmc_pkg::ST_SLEEP, 6);
    chk_val({5'h0, auxOn, padsOn, rstSeen | coreReset}, 8'h01);
    boostCapUv = 1'b0;
    pins(1'b1, 1'b1);
    wait_mode(gdmc_pkg::ST_IDLE, 8);
    chk_val(eventReg | spiStatus, 8'h00);
    note("sleep");
    gdmc_host_model_inst.cfg_write(1'b0);
    gdmc_host_model_inst.send_sig(cfgCrc);
    wait_mode(gdmc_pkg::ST_NORMAL, 130);
    limpReq = 1'b1;
    repeat (8) @(negedge clk);
    chk_mode(opMode, gdmc_pkg::ST_NORMAL);
    limpReq = 1'b0;
    pins(1'b0, 1'b1);
    wait_mode(gdmc_pkg::ST_PD_CB, 10);
    boostCapUv = 1'b1;
    wait_mode(gdmc_pkg::ST_SLEEP, 6);
    boostCapUv = 1'b0;
    pins(1'b1, 1'b1);
    wait_mode(gdmc_pkg::ST_IDLE, 8);
    gdmc_host_model_inst.cfg_write(1'b0);
    wait_mode(gdmc_pkg::ST_LOCK, 410);
    chk_val({6'h0, faultPin, gateOff}, 8'h01);
    note("lock");
    close_out();
  end
endmodule : gate_driver_mode_controller_tb
